// ===== hdl/aas_supervisor.sv
// Purpose: active antenna supervisor with APB registers and one interrupt
// Assumes: pins synchronous to pclk; external pull-ups on both sense inputs
// Notes: zero-wait APB slave; read data captured in the setup cycle
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "aas_defs.svh"
module aas_supervisor
   import aas_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int RETEST_CYCLES = `AAS_RETEST_CYCLES,
   parameter int SETTLE_CYCLES = `AAS_SETTLE_CYCLES,
   parameter logic [`AAS_CTRL_W-1:0] STORED_CFG = `AAS_CTRL_RESET
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // antenna pins
   input wire logic short_sense_low,
   input wire logic presence_sense,
   output logic antenna_supply_cut,
   // interrupt
   output logic irq
);

   // =====================================================
   // declarations
   logic [`AAS_CTRL_W-1:0] ctrl, next_ctrl;
   logic [`AAS_IRQ_W-1:0] irq_status, next_irq_status, irq_mask, next_irq_mask, irq_snap, next_irq_snap;
   logic [31:0] next_prdata, timer_value;
   logic setup_rd, access, addr_hit, short_now, open_now;
   logic supply_control_enable, short_detect_enable, short_auto_recover_enable, open_detect_enable;
   logic short_latched, next_short_latched, next_supply_cut, timer_load, timer_stop, timer_expired;
   logic ev_feat, ev_cond, ev_short;
   aas_seq_t seq, next_seq;
   aas_rec_t rec, next_rec;
   aas_cond_t cond, next_cond, sensed_cond;
   logic [`AAS_FEAT_W-1:0] feature_flags;

   // =====================================================
   // configuration bits
   assign supply_control_enable = ctrl[`AAS_CTRL_SUPPLY];
   assign short_detect_enable = ctrl[`AAS_CTRL_SHORTDET];
   assign short_auto_recover_enable = ctrl[`AAS_CTRL_RECOVER];
   assign open_detect_enable = ctrl[`AAS_CTRL_OPENDET];

   // feature report: control, short detect, open detect, power-down, recovery
   // power-down on short always comes with recovery, so both follow one enable
   assign feature_flags =
      {short_auto_recover_enable & short_detect_enable,
       short_auto_recover_enable & short_detect_enable,
       open_detect_enable,
       short_detect_enable,
       supply_control_enable};

   // =====================================================
   // sensing: short is a low level, open is presence low
   assign short_now = short_detect_enable & ~short_sense_low;
   assign open_now = open_detect_enable & ~presence_sense;

   // short wins over open; presence high or floating means connected
   assign sensed_cond = short_latched ? AAS_COND_SHORT :
      open_now ? AAS_COND_OPEN :
      AAS_COND_OK;

   // =====================================================
   // reporting sequence: feature report, then INIT, then live condition
   always_comb
   begin
      next_seq = seq;
      next_cond = cond;
      ev_feat = 1'b0;
      ev_cond = 1'b0;
      if (!supply_control_enable)
      begin
         // no feature or condition reports until supply control is on
         next_seq = AAS_SEQ_WAIT;
         next_cond = AAS_COND_INIT;
      end
      else
      begin
         case (seq)
            AAS_SEQ_WAIT:
            begin
               next_seq = AAS_SEQ_FEAT;
            end
            AAS_SEQ_FEAT:
            begin
               ev_feat = 1'b1;
               next_seq = AAS_SEQ_INIT;
            end
            AAS_SEQ_INIT:
            begin
               ev_cond = 1'b1;
               next_cond = AAS_COND_INIT;
               next_seq = AAS_SEQ_RUN;
            end
            AAS_SEQ_RUN:
            begin
               next_cond = sensed_cond;
               ev_cond = (sensed_cond != cond);
            end
            default:
            begin
               next_seq = AAS_SEQ_WAIT;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         seq <= AAS_SEQ_WAIT;
         cond <= AAS_COND_INIT;
      end
      else
      begin
         seq <= next_seq;
         cond <= next_cond;
      end
   end

   // =====================================================
   // short latch and recovery; a power cycle is the reset, which clears it
   always_comb
   begin
      next_rec = rec;
      next_short_latched = short_latched;
      next_supply_cut = 1'b0;
      timer_load = 1'b0;
      timer_value = 32'(RETEST_CYCLES);
      timer_stop = 1'b0;
      ev_short = 1'b0;
      if (!short_detect_enable)
      begin
         // disabling detection is the manual way out of a latched short
         next_short_latched = 1'b0;
         next_rec = AAS_REC_IDLE;
         timer_stop = 1'b1;
      end
      else
      begin
         case (rec)
            AAS_REC_IDLE:
            begin
               if (short_now && !short_latched)
               begin
                  next_short_latched = 1'b1;
                  ev_short = 1'b1;
                  if (short_auto_recover_enable && supply_control_enable)
                  begin
                     next_supply_cut = 1'b1;
                     timer_load = 1'b1;
                     next_rec = AAS_REC_CUT;
                  end
               end
            end
            AAS_REC_CUT:
            begin
               next_supply_cut = 1'b1;
               if (timer_expired)
               begin
                  // retest: restore power and let the sense line settle
                  next_supply_cut = 1'b0;
                  timer_load = 1'b1;
                  timer_value = 32'(SETTLE_CYCLES);
                  next_rec = AAS_REC_RETEST;
               end
            end
            AAS_REC_RETEST:
            begin
               if (timer_expired)
               begin
                  if (short_now)
                  begin
                     next_supply_cut = 1'b1;
                     timer_load = 1'b1;
                     next_rec = AAS_REC_CUT;
                  end
                  else
                  begin
                     next_short_latched = 1'b0;
                     next_rec = AAS_REC_IDLE;
                  end
               end
            end
            default:
            begin
               next_rec = AAS_REC_IDLE;
            end
         endcase
         // dropping recovery or supply control mid-cycle keeps the short latched
         if (rec != AAS_REC_IDLE && (!short_auto_recover_enable || !supply_control_enable))
         begin
            next_rec = AAS_REC_IDLE;
            next_supply_cut = 1'b0;
            timer_stop = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rec <= AAS_REC_IDLE;
         short_latched <= 1'b0;
         antenna_supply_cut <= 1'b0;
      end
      else
      begin
         rec <= next_rec;
         short_latched <= next_short_latched;
         antenna_supply_cut <= next_supply_cut;
      end
   end

   // retest and settle share one counter, never needed at once
   aas_timer #(.WIDTH(32)) u_timer
   (
      .pclk(pclk),
      .presetn(presetn),
      .load(timer_load),
      .load_value(timer_value),
      .stop(timer_stop),
      .expired(timer_expired)
   );

   // =====================================================
   // apb decode: zero wait states, unmapped addresses answer with pslverr
   assign pready = 1'b1;
   assign access = psel & penable;
   assign setup_rd = psel & ~penable & ~pwrite;
   assign addr_hit = paddr inside {`AAS_OFS_CTRL, `AAS_OFS_STATUS, `AAS_OFS_IRQ_STATUS, `AAS_OFS_IRQ_MASK};
   assign pslverr = access & ~addr_hit;

   // =====================================================
   // register file; read data captured in setup so it is stable in access
   always_comb
   begin
      next_ctrl = ctrl;
      next_irq_mask = irq_mask;
      next_prdata = prdata;
      next_irq_snap = irq_snap;
      if (setup_rd)
      begin
         next_prdata = 32'h0000_0000;
         next_irq_snap = '0;
         case (paddr)
            `AAS_OFS_CTRL:
            begin
               next_prdata[`AAS_CTRL_W-1:0] = ctrl;
            end
            `AAS_OFS_STATUS:
            begin
               next_prdata[`AAS_ST_COND_LSB +: 2] = cond;
               next_prdata[`AAS_ST_POWER] = supply_control_enable & ~antenna_supply_cut;
               next_prdata[`AAS_ST_FEAT_LSB +: `AAS_FEAT_W] = feature_flags;
            end
            `AAS_OFS_IRQ_STATUS:
            begin
               next_prdata[`AAS_IRQ_W-1:0] = irq_status;
               next_irq_snap = irq_status;
            end
            `AAS_OFS_IRQ_MASK:
            begin
               next_prdata[`AAS_IRQ_W-1:0] = irq_mask;
            end
            default:
            begin
               next_prdata = 32'h0000_0000;
            end
         endcase
      end
      if (access && pwrite)
      begin
         if (paddr == `AAS_OFS_CTRL)
         begin
            next_ctrl = pwdata[`AAS_CTRL_W-1:0];
         end
         if (paddr == `AAS_OFS_IRQ_MASK)
         begin
            next_irq_mask = pwdata[`AAS_IRQ_W-1:0];
         end
      end
   end

   // =====================================================
   // sticky events: only bits seen by the read are cleared, new events win
   always_comb
   begin
      next_irq_status = irq_status;
      if (access && !pwrite && paddr == `AAS_OFS_IRQ_STATUS)
      begin
         next_irq_status = irq_status & ~irq_snap;
      end
      next_irq_status[`AAS_IRQ_FEAT] = next_irq_status[`AAS_IRQ_FEAT] | ev_feat;
      next_irq_status[`AAS_IRQ_COND] = next_irq_status[`AAS_IRQ_COND] | ev_cond;
      next_irq_status[`AAS_IRQ_SHORT] = next_irq_status[`AAS_IRQ_SHORT] | ev_short;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= STORED_CFG;
         irq_mask <= `AAS_IRQ_RESET;
         irq_status <= `AAS_IRQ_RESET;
         irq_snap <= `AAS_IRQ_RESET;
         prdata <= 32'h0000_0000;
         irq <= 1'b0;
      end
      else
      begin
         ctrl <= next_ctrl;
         irq_mask <= next_irq_mask;
         irq_status <= next_irq_status;
         irq_snap <= next_irq_snap;
         prdata <= next_prdata;
         irq <= |(next_irq_status & next_irq_mask);
      end
   end

endmodule // aas_supervisor

// ===== hdl/aas_defs.svh
// Purpose: constants for the active antenna supervisor (offsets, fields, resets, timing)
// Assumes: 40 MHz pclk, 32-bit APB data, byte addresses
// Notes: included by bare name from the top module and the bench
`ifndef AAS_DEFS_SVH
`define AAS_DEFS_SVH

// =====================================================
// register offsets
`define AAS_OFS_CTRL 8'h00
`define AAS_OFS_STATUS 8'h04
`define AAS_OFS_IRQ_STATUS 8'h08
`define AAS_OFS_IRQ_MASK 8'h0C

// =====================================================
// control fields
`define AAS_CTRL_SUPPLY 0
`define AAS_CTRL_SHORTDET 1
`define AAS_CTRL_RECOVER 2
`define AAS_CTRL_OPENDET 3
`define AAS_CTRL_W 4
`define AAS_CTRL_RESET 4'h0

// =====================================================
// status fields: condition [1:0], power on [4], feature flags [12:8]
`define AAS_ST_COND_LSB 0
`define AAS_ST_POWER 4
`define AAS_ST_FEAT_LSB 8
`define AAS_FEAT_W 5

// =====================================================
// interrupt fields
`define AAS_IRQ_FEAT 0
`define AAS_IRQ_COND 1
`define AAS_IRQ_SHORT 2
`define AAS_IRQ_W 3
`define AAS_IRQ_RESET 3'h0

// =====================================================
// timing
`define AAS_CLK_HZ 40000000
`define AAS_RETEST_TIME_MS 1000
`define AAS_RETEST_CYCLES (`AAS_RETEST_TIME_MS * (`AAS_CLK_HZ / 1000))
`define AAS_SETTLE_CYCLES 4

`endif

// ===== hdl/aas_pkg.sv
// Purpose: types shared by the antenna supervisor files
// Assumes: nothing beyond the defs header
// Notes: constants live in aas_defs.svh
package aas_pkg;

   // reported antenna condition
   typedef enum logic [1:0]
   {
      AAS_COND_INIT = 2'b00,
      AAS_COND_OK = 2'b01,
      AAS_COND_SHORT = 2'b10,
      AAS_COND_OPEN = 2'b11
   } aas_cond_t;

   // reporting sequence after reset or after supply control enable
   typedef enum logic [1:0]
   {
      AAS_SEQ_WAIT = 2'b00,
      AAS_SEQ_FEAT = 2'b01,
      AAS_SEQ_INIT = 2'b10,
      AAS_SEQ_RUN = 2'b11
   } aas_seq_t;

   // short recovery machine
   typedef enum logic [1:0]
   {
      AAS_REC_IDLE = 2'b00,
      AAS_REC_CUT = 2'b01,
      AAS_REC_RETEST = 2'b10
   } aas_rec_t;

endpackage

// ===== hdl/aas_timer.sv
// Purpose: loadable down counter for retest timeout and settle wait
// Assumes: load has priority over counting
// Notes: expired is a one-cycle pulse load_value cycles after the load; the count stops at one
`timescale 1ns/1ps
module aas_timer
#(
   parameter int WIDTH = 32
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic load,
   input wire logic [WIDTH-1:0] load_value,
   input wire logic stop,
   // status
   output logic expired
);

   logic [WIDTH-1:0] count;
   logic running;
   logic [WIDTH-1:0] next_count;
   logic next_running;
   logic next_expired;

   // =====================================================
   // count down
   always_comb
   begin
      next_count = count;
      next_running = running;
      next_expired = 1'b0;
      if (stop)
      begin
         next_running = 1'b0;
      end
      else if (load)
      begin
         next_count = load_value;
         next_running = 1'b1;
      end
      else if (running)
      begin
         if (count <= WIDTH'(1))
         begin
            next_running = 1'b0;
            next_expired = 1'b1;
         end
         else
         begin
            next_count = count - WIDTH'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count <= '0;
         running <= 1'b0;
         expired <= 1'b0;
      end
      else
      begin
         count <= next_count;
         running <= next_running;
         expired <= next_expired;
      end
   end

endmodule // aas_timer

// ===== test/aas_properties.sv
// Purpose: port-level properties of the antenna supervisor
// Assumes: sees only the top ports; RETEST_CYCLES as handed to the top
// Notes: cut length is counted in helper logic, not by a long repetition
`timescale 1ns/1ps
module aas_props
#(
   parameter int RETEST_CYCLES = 20
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // antenna pins and interrupt
   input wire logic short_sense_low,
   input wire logic presence_sense,
   input wire logic antenna_supply_cut,
   input wire logic irq
);
   // =====================================================
   // helpers
   logic [31:0] cut_cnt;
   logic [31:0] next_cut_cnt;
   logic unmapped;
   assign unmapped = !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C});
   // counts sampled cycles with the feed cut, cleared when power returns
   always_comb
      next_cut_cnt = antenna_supply_cut ? cut_cnt + 32'h0000_0001 : 32'h0000_0000;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         cut_cnt <= 32'h0000_0000;
      else
         cut_cnt <= next_cut_cnt;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // =====================================================
   // properties
   property p_ready; pready; endproperty
   property p_slverr; pslverr |-> psel && penable && unmapped; endproperty
   property p_unmapped_zero; psel && !penable && !pwrite && unmapped |=> prdata == 32'h0000_0000; endproperty
   property p_cut_cause; $rose(antenna_supply_cut) |-> $past(short_sense_low) == 1'b0; endproperty
   // one cycle of slack either side: where the count starts is the designer's call
   property p_cut_len;
      $fell(antenna_supply_cut) |-> cut_cnt >= RETEST_CYCLES - 1 && cut_cnt <= RETEST_CYCLES + 1;
   endproperty
   property p_cut_bounded; cut_cnt <= RETEST_CYCLES + 1; endproperty
   property p_recut; $fell(antenna_supply_cut) ##1 !short_sense_low |-> ##[1:8] antenna_supply_cut; endproperty
   property p_ctrl_off;
      psel && penable && pwrite && paddr == 8'h00 && !(pwdata[0] && pwdata[2]) |-> ##[1:2] !antenna_supply_cut;
   endproperty
   property p_mask_off;
      psel && penable && pwrite && paddr == 8'h0C && pwdata[2:0] == 3'b000 |-> ##[1:2] !irq;
   endproperty

   a_ready: assert property (p_ready) else $error("pready low");
   a_slverr: assert property (p_slverr) else $error("pslverr outside unmapped access");
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
   a_cut_cause: assert property (p_cut_cause) else $error("cut without sensed short");
   a_cut_len: assert property (p_cut_len) else $error("cut length off");
   a_cut_bounded: assert property (p_cut_bounded) else $error("no retest after timeout");
   a_recut: assert property (p_recut) else $error("short at retest not cut again");
   a_ctrl_off: assert property (p_ctrl_off) else $error("cut without recovery enabled");
   a_mask_off: assert property (p_mask_off) else $error("irq high with zero mask");

   c_cut: cover property ($rose(antenna_supply_cut));
   c_err: cover property (pslverr);
   c_irq: cover property ($rose(irq));
endmodule // aas_props

bind aas_supervisor aas_props #(.RETEST_CYCLES(RETEST_CYCLES)) u_props (.pclk(pclk), .presetn(presetn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .short_sense_low(short_sense_low), .presence_sense(presence_sense),
   .antenna_supply_cut(antenna_supply_cut), .irq(irq));

// ===== test/aas_antenna_model.sv
// Purpose: behavioural antenna feed with short and presence sense
// Assumes: both sense lines pulled up on the board
// Notes: a short shows only while the feed is powered
`timescale 1ns/1ps
module aas_antenna_model
(
   // control from the supervisor
   input wire logic antenna_supply_cut,
   // faults set by the bench
   input wire logic shorted,
   input wire logic missing,
   // sense lines
   output logic short_sense_low,
   output logic presence_sense
);
   // =====================================================
   // sense lines
   // a cut feed carries no current, so the pull-up wins even with a short
   assign short_sense_low = !(shorted && !antenna_supply_cut);
   assign presence_sense = !missing; // floating line is pulled high
endmodule // aas_antenna_model

// ===== test/aas_supervisor_tb_top.sv
// Purpose: self-checking bench for the antenna supervisor
// Assumes: zero-wait apb slave; short retest count cut down for sim
// Notes: read results are noted in a queue and checked by a monitor
`timescale 1ns/1ps
`include "aas_defs.svh"
module active_antenna_supervisor_tb_top
   import aas_pkg::*;
;
   localparam int RETEST = 20;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic short_sense_low, presence_sense, antenna_supply_cut, shorted, missing;
   logic [7:0] paddr, a;
   logic [31:0] pwdata, prdata;
   logic [33:0] exp_q[$];
   logic [33:0] note;
   int error_cnt = 0;
   int comparisons = 0;

   aas_supervisor #(.RETEST_CYCLES(RETEST), .STORED_CFG(4'h3)) u_dut (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .short_sense_low(short_sense_low), .presence_sense(presence_sense),
      .antenna_supply_cut(antenna_supply_cut), .irq(irq));
   aas_antenna_model u_ant (.antenna_supply_cut(antenna_supply_cut), .shorted(shorted), .missing(missing),
      .short_sense_low(short_sense_low), .presence_sense(presence_sense));

   // =====================================================
   // helpers
   function automatic logic [31:0] st(input logic [1:0] c, input logic pw, input logic [4:0] f);
      return {19'h0, f, 3'h0, pw, 2'h0, c};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one apb transfer, then an idle edge so psel is never set twice in a step
   task automatic apb(input logic [7:0] ad, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= ad;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      apb(ad, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] ad, input logic c, input logic [31:0] e);
      // an address outside the register map must answer with an error
      exp_q.push_back({c, !(ad inside {`AAS_OFS_CTRL, `AAS_OFS_STATUS, `AAS_OFS_IRQ_STATUS, `AAS_OFS_IRQ_MASK}), e});
      apb(ad, 1'b0, 32'h0000_0000);
   endtask
   task automatic end_of_test();
      if (error_cnt == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // =====================================================
   // clock, monitor, watchdog
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // read data taken at the edge that completes the access
   always @(posedge pclk)
      if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0)
      begin
         note = exp_q.pop_front();
         if (note[33])
            chk(prdata, note[31:0]);
         chk(32'(pslverr), 32'(note[32]));
      end
   initial
   begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      end_of_test();
   end

   // =====================================================
   // scenarios
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      shorted = 1'b0;
      missing = 1'b0;
      void'($urandom(69));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      idle(10);
      // stored configuration replays its reports after reset
      rd(`AAS_OFS_CTRL, 1'b1, 32'h0000_0003);
      rd(`AAS_OFS_STATUS, 1'b1, st(AAS_COND_OK, 1'b1, 5'h03));
      rd(`AAS_OFS_IRQ_STATUS, 1'b1, 32'h0000_0003);
      rd(`AAS_OFS_IRQ_STATUS, 1'b1, 32'h0000_0000);
      chk(32'(antenna_supply_cut), 32'h0000_0000);
      // unmapped places read zero and ignore writes
      repeat (4)
      begin
         a = 8'h10 + 8'($urandom_range(0, 59) * 4);
         wr(a, $urandom);
         rd(a, 1'b1, 32'h0000_0000);
      end
      rd(`AAS_OFS_CTRL, 1'b1, 32'h0000_0003);
      // short without recovery: reported and latched, power stays on
      wr(`AAS_OFS_IRQ_MASK, 32'h0000_0004);
      shorted <= 1'b1;
      idle(6);
      chk(32'(irq), 32'h0000_0001);
      chk(32'(antenna_supply_cut), 32'h0000_0000);
      rd(`AAS_OFS_STATUS, 1'b1, st(AAS_COND_SHORT, 1'b1, 5'h03));
      wr(`AAS_OFS_IRQ_MASK, 32'h0000_0000);
      chk(32'(irq), 32'h0000_0000);
      rd(`AAS_OFS_IRQ_STATUS, 1'b1, 32'h0000_0006);
      shorted <= 1'b0;
      idle(4 + $urandom_range(0, 3));
      rd(`AAS_OFS_STATUS, 1'b1, st(AAS_COND_SHORT, 1'b1, 5'h03));
      wr(`AAS_OFS_CTRL, 32'h0000_0001);
      wr(`AAS_OFS_CTRL, 32'h0000_0003);
      idle(6);
      rd(`AAS_OFS_STATUS, 1'b1, st(AAS_COND_OK, 1'b1, 5'h03));
      // short detection off: a short goes unreported
      wr(`AAS_OFS_CTRL, 32'h0000_0001);
      shorted <= 1'b1;
      idle(6);
      rd(`AAS_OFS_STATUS, 1'b1, st(AAS_COND_OK, 1'b1, 5'h01));
      shorted <= 1'b0;
      // supply control off: no reports at all
      wr(`AAS_OFS_CTRL, 32'h0000_0000);
      idle(6);
      rd(`AAS_OFS_IRQ_STATUS, 1'b0, 32'h0000_0000);
      missing <= 1'b1;
      idle(6);
      rd(`AAS_OFS_IRQ_STATUS, 1'b1, 32'h0000_0000);
      rd(`AAS_OFS_STATUS, 1'b1, 32'h0000_0000);
      missing <= 1'b0;
      // open detection reports a missing antenna and its return
      wr(`AAS_OFS_CTRL, 32'h0000_000B);
      idle(10);
      rd(`AAS_OFS_STATUS, 1'b1, st(AAS_COND_OK, 1'b1, 5'h07));
      missing <= 1'b1;
      idle(4 + $urandom_range(0, 3));
      rd(`AAS_OFS_STATUS, 1'b1, st(AAS_COND_OPEN, 1'b1, 5'h07));
      missing <= 1'b0;
      idle(6);
      rd(`AAS_OFS_STATUS, 1'b1, st(AAS_COND_OK, 1'b1, 5'h07));
      // auto recovery cuts power, retests through a failed try, restores
      wr(`AAS_OFS_CTRL, 32'h0000_0007);
      idle(10);
      rd(`AAS_OFS_STATUS, 1'b1, st(AAS_COND_OK, 1'b1, 5'h1B));
      shorted <= 1'b1;
      idle(4);
      chk(32'(antenna_supply_cut), 32'h0000_0001);
      rd(`AAS_OFS_STATUS, 1'b1, st(AAS_COND_SHORT, 1'b0, 5'h1B));
      idle(RETEST + 10);
      shorted <= 1'b0;
      idle(2 * RETEST + 20);
      chk(32'(antenna_supply_cut), 32'h0000_0000);
      rd(`AAS_OFS_STATUS, 1'b1, st(AAS_COND_OK, 1'b1, 5'h1B));
      idle(4);
      end_of_test();
   end
endmodule // active_antenna_supervisor_tb_top
